// ==== design/drive_input_function_control.sv ====
// Function
// - Active source-switch input selects alternate analog input instead of unipolar input.
// - Source selection 01 (default) uses the three analog terminals as setpoint.
// - Changeover target 00 picks current loop, 01 picks bipolar input.
// - Bipolar mode 00 alone, 01 sum unsigned, 02 sum with reversal.
// - A terminal with function code 16 acts as source-switch input.
// - Factory default assigns source-switch to terminal 2.
// - Active second-ramp input uses second ramp times, else first.
// - Second accel/decel times range 0.01..3600 s, default 15, writable running.
// - Ramp trigger 00 uses input level, 01 uses changeover frequencies.
// - A terminal with function code 09 acts as second-ramp input.
// - Factory default assigns second-ramp to terminal 5.
// - Active coast input switches output off so motor coasts.
// - On release, policy 00 restarts at 0 Hz, 01 waits then resyncs.
// - Restart delay 0.3..100 s, default 1.0; waiting indication shown meanwhile.
// - Resync starts driving once sensed speed reaches resync frequency, 0..400 Hz.
// - A terminal with function code 11 acts as coast input.
// - Factory default assigns coast to terminal 4.
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_control
  import input_function_pkg::*;
#(
  parameter int DELAY_TICK = DELAY_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_INPUTS-1:0] digitalIn,
  input wire logic signed [15:0] unipolarVoltage,
  input wire logic signed [15:0] bipolar_voltage_input,
  input wire logic signed [15:0] current_loop_input,
  input wire logic signed [15:0] keypadSetpoint,
  input wire logic [15:0] outputFreq,
  input wire logic [15:0] sensedRotorFreq,
  output logic signed [16:0] setpoint_q,
  output logic reverseDir_q,
  output logic setpointValid_q,
  output logic useRamp2_q,
  output logic [18:0] accelTime_q,
  output logic [18:0] decelTime_q,
  output logic outputEnable_q,
  output logic startFromZero_q,
  output logic waitIndicator_q
);
  import input_function_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_INPUTS-1:0] inSync;
  logic analog_source_switch;
  logic second_ramp_select;
  logic coast_inhibit;
  logic [1:0] setpoint_source_sel_q;
  logic [1:0] changeover_target_q;
  logic [1:0] bipolar_input_mode_q;
  logic [1:0] ramp2_trigger_q;
  logic [18:0] ramp2_accel_time_q;
  logic [18:0] ramp2_decel_time_q;
  logic [18:0] ramp1AccelTime_q;
  logic [18:0] ramp1DecelTime_q;
  logic [15:0] ramp2_accel_switch_freq_q;
  logic [15:0] ramp2_decel_switch_freq_q;
  logic [1:0] restart_policy_q;
  logic [9:0] restart_delay_q;
  logic [15:0] resync_frequency_q;
  logic [8*NUM_INPUTS-1:0] input_function_sel_q;
  run_state_t state_q;
  logic [31:0] tick_q;
  logic [9:0] delayCnt_q;
  logic coastPrev_q;
  logic [15:0] prevFreq_q;

  input_sync #(.WIDTH(NUM_INPUTS)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(digitalIn),
    .syncOut(inSync)
  );

  function_decode #(.N(NUM_INPUTS)) u_dec_switch (
    .level(inSync),
    .fnSel(input_function_sel_q),
    .code(FN_ANALOG_SWITCH),
    .active(analog_source_switch)
  );

  function_decode #(.N(NUM_INPUTS)) u_dec_ramp2 (
    .level(inSync),
    .fnSel(input_function_sel_q),
    .code(FN_RAMP2),
    .active(second_ramp_select)
  );

  function_decode #(.N(NUM_INPUTS)) u_dec_coast (
    .level(inSync),
    .fnSel(input_function_sel_q),
    .code(FN_COAST),
    .active(coast_inhibit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: classic Wishbone slave, ack one cycle after stb; a write lands on the
  // edge that samples ack high, the only edge at which the master vouches for its data.
  logic busReq;
  logic wrEn;
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrEn = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_sel_i == 4'hf);

  function automatic logic [7:0] defaultFn(input int term);
    if (term == DEF_ANALOG_SWITCH_TERM) begin
      defaultFn = FN_ANALOG_SWITCH;
    end else if (term == DEF_COAST_TERM) begin
      defaultFn = FN_COAST;
    end else if (term == DEF_RAMP2_TERM) begin
      defaultFn = FN_RAMP2;
    end else begin
      defaultFn = 8'h00;
    end
  endfunction : defaultFn

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      setpoint_source_sel_q <= SETPOINT_SRC_RST;
      changeover_target_q <= CHANGEOVER_RST;
      bipolar_input_mode_q <= BIPOLAR_MODE_RST;
      ramp2_trigger_q <= RAMP2_TRIG_RST;
      restart_policy_q <= RESTART_POLICY_RST;
    end else if (wrEn) begin
      unique case (wb_adr_i)
        REG_SETPOINT_SRC: setpoint_source_sel_q <= wb_dat_i[1:0];
        REG_CHANGEOVER: changeover_target_q <= wb_dat_i[1:0];
        REG_BIPOLAR_MODE: bipolar_input_mode_q <= wb_dat_i[1:0];
        REG_RAMP2_TRIG: ramp2_trigger_q <= wb_dat_i[1:0];
        REG_RESTART_POLICY: restart_policy_q <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // Times accept writes at any moment, including while running; out-of-range
  // values are clamped rather than refused so software always sees a legal value.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ramp2_accel_time_q <= RAMP2_TIME_RST;
      ramp2_decel_time_q <= RAMP2_TIME_RST;
      ramp1AccelTime_q <= RAMP2_TIME_RST;
      ramp1DecelTime_q <= RAMP2_TIME_RST;
      ramp2_accel_switch_freq_q <= SWITCH_FREQ_RST;
      ramp2_decel_switch_freq_q <= SWITCH_FREQ_RST;
      restart_delay_q <= RESTART_DELAY_RST;
      resync_frequency_q <= RESYNC_FREQ_RST;
    end else if (wrEn) begin
      unique case (wb_adr_i)
        REG_RAMP2_ACCEL: ramp2_accel_time_q <=
            19'(clampVal(wb_dat_i, 32'(RAMP_TIME_MIN), 32'(RAMP_TIME_MAX)));
        REG_RAMP2_DECEL: ramp2_decel_time_q <=
            19'(clampVal(wb_dat_i, 32'(RAMP_TIME_MIN), 32'(RAMP_TIME_MAX)));
        REG_ACCEL_SW_FREQ: ramp2_accel_switch_freq_q <=
            16'(clampVal(wb_dat_i, 32'h0, 32'(FREQ_MAX)));
        REG_DECEL_SW_FREQ: ramp2_decel_switch_freq_q <=
            16'(clampVal(wb_dat_i, 32'h0, 32'(FREQ_MAX)));
        REG_RESTART_DELAY: restart_delay_q <=
            10'(clampVal(wb_dat_i, 32'(RESTART_DELAY_MIN), 32'(RESTART_DELAY_MAX)));
        REG_RESYNC_FREQ: resync_frequency_q <=
            16'(clampVal(wb_dat_i, 32'h0, 32'(FREQ_MAX)));
        REG_RAMP1_ACCEL: ramp1AccelTime_q <=
            19'(clampVal(wb_dat_i, 32'(RAMP_TIME_MIN), 32'(RAMP_TIME_MAX)));
        REG_RAMP1_DECEL: ramp1DecelTime_q <=
            19'(clampVal(wb_dat_i, 32'(RAMP_TIME_MIN), 32'(RAMP_TIME_MAX)));
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        input_function_sel_q[8*i +: 8] <= defaultFn(i + 1);
      end
    end else if (wrEn && wb_adr_i >= REG_INPUT_FN_BASE &&
                 wb_adr_i < REG_INPUT_FN_BASE + 8'(4 * NUM_INPUTS) && wb_adr_i[1:0] == 2'b00) begin
      input_function_sel_q[8*(3'(wb_adr_i[4:2])) +: 8] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0;
    end else if (busReq) begin
      wb_dat_o <= 32'h0;
      if (wb_adr_i >= REG_INPUT_FN_BASE && wb_adr_i < REG_INPUT_FN_BASE + 8'(4 * NUM_INPUTS)) begin
        wb_dat_o <= {24'h0, input_function_sel_q[8*(3'(wb_adr_i[4:2])) +: 8]};
      end else begin
        unique case (wb_adr_i)
          REG_SETPOINT_SRC: wb_dat_o <= {30'h0, setpoint_source_sel_q};
          REG_CHANGEOVER: wb_dat_o <= {30'h0, changeover_target_q};
          REG_BIPOLAR_MODE: wb_dat_o <= {30'h0, bipolar_input_mode_q};
          REG_RAMP2_TRIG: wb_dat_o <= {30'h0, ramp2_trigger_q};
          REG_RAMP2_ACCEL: wb_dat_o <= {13'h0, ramp2_accel_time_q};
          REG_RAMP2_DECEL: wb_dat_o <= {13'h0, ramp2_decel_time_q};
          REG_ACCEL_SW_FREQ: wb_dat_o <= {16'h0, ramp2_accel_switch_freq_q};
          REG_DECEL_SW_FREQ: wb_dat_o <= {16'h0, ramp2_decel_switch_freq_q};
          REG_RESTART_POLICY: wb_dat_o <= {30'h0, restart_policy_q};
          REG_RESTART_DELAY: wb_dat_o <= {22'h0, restart_delay_q};
          REG_RESYNC_FREQ: wb_dat_o <= {16'h0, resync_frequency_q};
          REG_STATUS: wb_dat_o <= {19'h0, state_q, analog_source_switch, second_ramp_select,
                                   coast_inhibit, inSync};
          REG_RAMP1_ACCEL: wb_dat_o <= {13'h0, ramp1AccelTime_q};
          REG_RAMP1_DECEL: wb_dat_o <= {13'h0, ramp1DecelTime_q};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint selection.
  logic signed [16:0] mainIn;
  logic signed [16:0] sumIn;
  logic signed [16:0] spNext;
  always_comb begin
    mainIn = 17'(unipolarVoltage);
    if (analog_source_switch && changeover_target_q == 2'h0) begin
      mainIn = 17'(current_loop_input);
    end
    sumIn = mainIn + 17'(bipolar_voltage_input);
    spNext = mainIn;
    if (analog_source_switch && changeover_target_q == 2'h1) begin
      spNext = 17'(bipolar_voltage_input);
    end else begin
      unique case (bipolar_input_mode_q)
        2'h1: spNext = (sumIn < 0) ? 17'sh0 : sumIn;
        2'h2: spNext = sumIn;
        default: spNext = mainIn;
      endcase
    end
  end

  // Non-analog sources fall back to the keypad value; the bus and option card
  // sources live outside this block, yet valid drops only for selection 3.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      setpoint_q <= 17'sh0;
      reverseDir_q <= 1'b0;
      setpointValid_q <= 1'b0;
    end else if (setpoint_source_sel_q == SETPOINT_SRC_RST) begin
      setpoint_q <= (spNext < 0) ? -spNext : spNext;
      reverseDir_q <= (bipolar_input_mode_q == 2'h2 || (analog_source_switch &&
                       changeover_target_q == 2'h1)) && spNext < 0;
      setpointValid_q <= 1'b1;
    end else begin
      setpoint_q <= 17'(keypadSetpoint);
      reverseDir_q <= 1'b0;
      setpointValid_q <= setpoint_source_sel_q <= 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp selection.
  logic rampAuto;
  always_comb begin
    rampAuto = (outputFreq >= ramp2_accel_switch_freq_q && outputFreq >= prevFreq_q) ||
               (outputFreq <= ramp2_decel_switch_freq_q && outputFreq < prevFreq_q);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prevFreq_q <= 16'h0;
      useRamp2_q <= 1'b0;
      accelTime_q <= RAMP2_TIME_RST;
      decelTime_q <= RAMP2_TIME_RST;
    end else begin
      prevFreq_q <= outputFreq;
      useRamp2_q <= (ramp2_trigger_q == 2'h1) ? rampAuto : second_ramp_select;
      accelTime_q <= useRamp2_q ? ramp2_accel_time_q : ramp1AccelTime_q;
      decelTime_q <= useRamp2_q ? ramp2_decel_time_q : ramp1DecelTime_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coast and restart sequencer.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= RUN_NORMAL;
      tick_q <= 32'h0;
      delayCnt_q <= 10'h0;
      coastPrev_q <= 1'b0;
    end else begin
      coastPrev_q <= coast_inhibit;
      if (coast_inhibit) begin
        state_q <= RUN_COAST;
      end else begin
        unique case (state_q)
          RUN_NORMAL: state_q <= RUN_NORMAL;
          RUN_COAST: begin
            tick_q <= 32'h0;
            delayCnt_q <= 10'h0;
            state_q <= (restart_policy_q == 2'h1) ? RUN_WAIT : RUN_NORMAL;
          end
          RUN_WAIT: begin
            if (tick_q >= 32'(DELAY_TICK - 1)) begin
              tick_q <= 32'h0;
              delayCnt_q <= delayCnt_q + 10'h1;
              if (delayCnt_q + 10'h1 >= restart_delay_q) begin
                state_q <= RUN_RESYNC;
              end
            end else begin
              tick_q <= tick_q + 32'h1;
            end
          end
          RUN_RESYNC: begin
            if (sensedRotorFreq <= resync_frequency_q) begin
              state_q <= RUN_NORMAL;
            end
          end
        endcase
      end
    end
  end

  // Outputs follow the next state so they switch on the same edge, except waitIndicator_q, which stays high for one cycle after RUN_WAIT ends.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outputEnable_q <= 1'b1;
      startFromZero_q <= 1'b0;
      waitIndicator_q <= 1'b0;
    end else begin
      outputEnable_q <= !coast_inhibit && (state_q == RUN_NORMAL ||
                        (state_q == RUN_COAST && restart_policy_q != 2'h1) ||
                        (state_q == RUN_RESYNC && sensedRotorFreq <= resync_frequency_q));
      startFromZero_q <= !coast_inhibit && coastPrev_q && restart_policy_q != 2'h1;
      waitIndicator_q <= !coast_inhibit && (state_q == RUN_WAIT ||
                         (state_q == RUN_COAST && restart_policy_q == 2'h1));
    end
  end
endmodule : drive_input_function_control
`default_nettype wire

// ==== design/function_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module function_decode
  import input_function_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic [N-1:0] level,
  input wire logic [8*N-1:0] fnSel,
  input wire logic [7:0] code,
  output logic active
);
  // Any terminal whose selection holds the code drives the function (OR).
  always_comb begin
    active = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (fnSel[8*i +: 8] == code && level[i]) begin
        active = 1'b1;
      end
    end
  end
endmodule : function_decode
`default_nettype wire

// ==== design/input_function_pkg.sv ====
package input_function_pkg;

  // Input-function codes held in the per-terminal selection registers.
  localparam logic [7:0] FN_ANALOG_SWITCH = 8'h10;
  localparam logic [7:0] FN_RAMP2 = 8'h09;
  localparam logic [7:0] FN_COAST = 8'h0b;
  localparam int NUM_INPUTS = 8;

  // Register word offsets (byte addresses).
  localparam logic [7:0] REG_SETPOINT_SRC = 8'h00;
  localparam logic [7:0] REG_CHANGEOVER = 8'h04;
  localparam logic [7:0] REG_BIPOLAR_MODE = 8'h08;
  localparam logic [7:0] REG_RAMP2_TRIG = 8'h0c;
  localparam logic [7:0] REG_RAMP2_ACCEL = 8'h10;
  localparam logic [7:0] REG_RAMP2_DECEL = 8'h14;
  localparam logic [7:0] REG_ACCEL_SW_FREQ = 8'h18;
  localparam logic [7:0] REG_DECEL_SW_FREQ = 8'h1c;
  localparam logic [7:0] REG_RESTART_POLICY = 8'h20;
  localparam logic [7:0] REG_RESTART_DELAY = 8'h24;
  localparam logic [7:0] REG_RESYNC_FREQ = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2c;
  localparam logic [7:0] REG_RAMP1_ACCEL = 8'h30;
  localparam logic [7:0] REG_RAMP1_DECEL = 8'h34;
  localparam logic [7:0] REG_INPUT_FN_BASE = 8'h40;

  // Reset (factory default) values.
  localparam logic [1:0] SETPOINT_SRC_RST = 2'h1;
  localparam logic [1:0] CHANGEOVER_RST = 2'h0;
  localparam logic [1:0] BIPOLAR_MODE_RST = 2'h0;
  localparam logic [1:0] RAMP2_TRIG_RST = 2'h0;
  localparam logic [1:0] RESTART_POLICY_RST = 2'h0;
  // Ramp times in units of 10 ms: 1..360000, default 15 s.
  localparam logic [18:0] RAMP_TIME_MIN = 19'h00001;
  localparam logic [18:0] RAMP_TIME_MAX = 19'h57e40;
  localparam logic [18:0] RAMP2_TIME_RST = 19'h005dc;
  // Restart delay in units of 100 ms: 3..1000, default 1.0 s.
  localparam logic [9:0] RESTART_DELAY_MIN = 10'h003;
  localparam logic [9:0] RESTART_DELAY_MAX = 10'h3e8;
  localparam logic [9:0] RESTART_DELAY_RST = 10'h00a;
  // Frequencies in units of 0.01 Hz: 0..40000.
  localparam logic [15:0] FREQ_MAX = 16'h9c40;
  localparam logic [15:0] RESYNC_FREQ_RST = 16'h0000;
  localparam logic [15:0] SWITCH_FREQ_RST = 16'h0000;
  // Default terminal assignment of each input function (1-based terminal).
  localparam int DEF_ANALOG_SWITCH_TERM = 2;
  localparam int DEF_COAST_TERM = 4;
  localparam int DEF_RAMP2_TERM = 5;

  // Restart delay tick: 100 ms at 100 MHz.
  localparam int CLK_MHZ = 100;
  localparam int DELAY_TICK_MS = 100;
  localparam int DELAY_TICK_CYCLES = DELAY_TICK_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    RUN_NORMAL = 2'b00,
    RUN_COAST = 2'b01,
    RUN_WAIT = 2'b10,
    RUN_RESYNC = 2'b11
  } run_state_t;

  function automatic logic [31:0] clampVal(input logic [31:0] v, input logic [31:0] lo,
                                           input logic [31:0] hi);
    clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampVal

endpackage : input_function_pkg

// ==== design/input_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : input_sync
`default_nettype wire

// ==== verification/drive_input_function_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [input_function_pkg::NUM_INPUTS-1:0] digitalIn,
  input wire logic outputEnable_q,
  input wire logic startFromZero_q,
  input wire logic waitIndicator_q
);
  import input_function_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> !wb_ack_o)
    else $error("ack without request");
  coast_stop_a: assert property ($rose(digitalIn[3]) && outputEnable_q |=> outputEnable_q ##[1:2] !outputEnable_q)
    else $error("coast terminal did not stop drive on time");
  coast_hold_a: assert property (digitalIn[3] [*5] |-> !outputEnable_q)
    else $error("drive on while coast terminal held");
  start_pulse_a: assert property (startFromZero_q |=> !startFromZero_q)
    else $error("zero start flag longer than one cycle");
  start_nowait_a: assert property (startFromZero_q |-> !waitIndicator_q)
    else $error("zero start during restart wait");
  wait_off_a: assert property (waitIndicator_q |-> !outputEnable_q)
    else $error("drive on during restart wait");
endmodule : drive_input_function_sva
bind drive_input_function_control drive_input_function_sva chk (.mclk(mclk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .digitalIn(digitalIn),
  .outputEnable_q(outputEnable_q), .startFromZero_q(startFromZero_q),
  .waitIndicator_q(waitIndicator_q));
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  import input_function_pkg::*;
  typedef struct {int sel; logic [31:0] exp;} note_t;
  logic mclk, rst_n, cyc, stb, we, ack, revDir, valid, ramp2, outEn, zStart, waitInd;
  logic startSeen;
  logic [7:0] adr, term, termIn;
  logic [31:0] wdat, rdat;
  logic [15:0] uni, bip, cur, ofreq, rotor, x, freqIn, rotorIn;
  logic signed [15:0] uniIn, bipIn, curIn;
  logic signed [16:0] setpoint;
  logic [18:0] accT, decT;
  note_t notes[$];
  note_t nt;
  int numErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  string portNm [11] = '{"rdat", "setpoint", "reverse", "ramp2", "accel", "decel",
    "enable", "zstart", "wait", "valid", "zseen"};
  logic [7:0] rAdr [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28,
    8'h44, 8'h4c, 8'h50, 8'h38};
  logic [31:0] rVal [13] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h5dc, 32'h5dc, 32'h0, 32'ha,
    32'h0, 32'h10, 32'h0b, 32'h09, 32'h0};
  terminal_model partner (.mclk(mclk), .termReq(term), .uniReq(uni), .bipReq(bip),
    .curReq(cur), .freqReq(ofreq), .rotorReq(rotor), .termOut(termIn), .uniOut(uniIn),
    .bipOut(bipIn), .curOut(curIn), .freqOut(freqIn), .rotorOut(rotorIn));
  drive_input_function_control #(.DELAY_TICK(10)) dut (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .digitalIn(termIn),
    .unipolarVoltage(uniIn), .bipolar_voltage_input(bipIn), .current_loop_input(curIn),
    .keypadSetpoint(16'sh0000), .outputFreq(freqIn), .sensedRotorFreq(rotorIn),
    .setpoint_q(setpoint), .reverseDir_q(revDir), .setpointValid_q(valid),
    .useRamp2_q(ramp2), .accelTime_q(accT), .decelTime_q(decT), .outputEnable_q(outEn),
    .startFromZero_q(zStart), .waitIndicator_q(waitInd));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic logic [31:0] portVal(input int s);
    case (s)
      0: portVal = rdat;
      1: portVal = {{15{setpoint[16]}}, setpoint};
      2: portVal = {31'h0, revDir};
      3: portVal = {31'h0, ramp2};
      4: portVal = {13'h0, accT};
      5: portVal = {13'h0, decT};
      6: portVal = {31'h0, outEn};
      7: portVal = {31'h0, zStart};
      8: portVal = {31'h0, waitInd};
      9: portVal = {31'h0, valid};
      default: portVal = {31'h0, startSeen};
    endcase
  endfunction : portVal
  task automatic final_report();
    if (numErrors == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic expectPort(input int s, input logic [31:0] e);
    notes.push_back('{s, e});
  endtask : expectPort
  // The request holds until ack is seen, then an idle cycle keeps requests apart.
  task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask : wbCycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expectPort(0, e);
    wbCycle(1'b0, a, 32'h0);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (zStart === 1'b1) startSeen <= 1'b1;
    if (cycles > 3000) begin
      numErrors++;
      final_report();
    end
  end
  // Read notes wait for ack; level notes are compared at the next falling edge that finds no read note ahead of them.
  always @(negedge mclk) begin
    while (notes.size() > 0 && (notes[0].sel != 0 || ack === 1'b1)) begin
      nt = notes.pop_front();
      `CHK(portNm[nt.sel], nt.exp, portVal(nt.sel))
      if (nt.sel == 0) break;
    end
  end
  initial begin
    {rst_n, cyc, stb, we, adr, wdat, term, ofreq, rotor, startSeen} = '0;
    x = 16'hd9f8;
    uni = 16'h0;
    bip = 16'h0;
    cur = 16'h0;
    settle(2);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 13; i++) rd(rAdr[i], rVal[i]);
    x = lfsr(x);
    uni <= {4'h0, x[11:0]};
    x = lfsr(x);
    cur <= {4'h0, x[11:0]};
    x = lfsr(x);
    bip <= {4'h0, x[11:0]};
    settle(6);
    expectPort(1, 32'(uni));
    expectPort(9, 32'h1);
    term <= 8'h02;
    settle(6);
    expectPort(1, 32'(cur));
    wbCycle(1'b1, 8'h04, 32'h1);
    settle(4);
    expectPort(1, 32'(bip));
    term <= 8'h00;
    wbCycle(1'b1, 8'h08, 32'h1);
    settle(6);
    expectPort(1, 32'(uni) + 32'(bip));
    bip <= 16'hf000;
    settle(6);
    expectPort(1, 32'h0);
    expectPort(2, 32'h0);
    wbCycle(1'b1, 8'h08, 32'h2);
    settle(6);
    expectPort(1, 32'h1000 - 32'(uni));
    expectPort(2, 32'h1);
    bip <= 16'h0456;
    wbCycle(1'b1, 8'h08, 32'h0);
    wbCycle(1'b1, 8'h44, 32'h0);
    wbCycle(1'b1, 8'h40, 32'(FN_ANALOG_SWITCH));
    term <= 8'h01;
    settle(6);
    expectPort(1, 32'h0456);
    term <= 8'h00;
    wbCycle(1'b1, 8'h10, 32'h0);
    rd(8'h10, 32'h1);
    wbCycle(1'b1, 8'h14, 32'h7ffff);
    rd(8'h14, 32'h57e40);
    term <= 8'h10;
    settle(6);
    expectPort(3, 32'h1);
    expectPort(5, 32'h57e40);
    wbCycle(1'b1, 8'h10, 32'h64);
    settle(3);
    expectPort(4, 32'h64);
    term <= 8'h00;
    settle(6);
    expectPort(3, 32'h0);
    expectPort(4, 32'h5dc);
    wbCycle(1'b1, 8'h0c, 32'h1);
    wbCycle(1'b1, 8'h18, 32'd1000);
    for (int f = 900; f <= 1200; f += 10) begin
      ofreq <= 16'(f);
      @(posedge mclk);
    end
    expectPort(3, 32'h1);
    term <= 8'h08;
    settle(6);
    expectPort(6, 32'h0);
    term <= 8'h00;
    settle(8);
    expectPort(10, 32'h1);
    expectPort(6, 32'h1);
    wbCycle(1'b1, 8'h20, 32'h1);
    wbCycle(1'b1, 8'h24, 32'h1);
    rd(8'h24, 32'h3);
    wbCycle(1'b1, 8'h28, 32'hc350);
    rd(8'h28, 32'h9c40);
    wbCycle(1'b1, 8'h28, 32'd500);
    rotor <= 16'd2000;
    startSeen <= 1'b0;
    term <= 8'h08;
    settle(6);
    term <= 8'h00;
    settle(10);
    expectPort(8, 32'h1);
    expectPort(6, 32'h0);
    settle(40);
    expectPort(8, 32'h0);
    expectPort(6, 32'h0);
    rotor <= 16'd400;
    settle(6);
    expectPort(6, 32'h1);
    expectPort(10, 32'h0);
    settle(2);
    final_report();
  end
endmodule : tb
`default_nettype wire

// ==== verification/terminal_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module terminal_model (
  input wire logic mclk,
  input wire logic [7:0] termReq,
  input wire logic [15:0] uniReq,
  input wire logic [15:0] bipReq,
  input wire logic [15:0] curReq,
  input wire logic [15:0] freqReq,
  input wire logic [15:0] rotorReq,
  output logic [7:0] termOut,
  output logic signed [15:0] uniOut,
  output logic signed [15:0] bipOut,
  output logic signed [15:0] curOut,
  output logic [15:0] freqOut,
  output logic [15:0] rotorOut
);
  // Terminals and samples move only after an edge, so the sampler sees no glitch.
  always_ff @(posedge mclk) begin
    termOut <= termReq;
    uniOut <= uniReq;
    bipOut <= bipReq;
    curOut <= curReq;
    freqOut <= freqReq;
    rotorOut <= rotorReq;
  end
endmodule : terminal_model
`default_nettype wire
